// >>> verilog/dfp_pkg.sv
// Shared constants for the digital frequency pull control link and its two ends.
package dfp_pkg;

  // Device register indices on the link.
  localparam logic [1:0] REG_WORD_LOW = 2'h0;
  localparam logic [1:0] REG_ENABLE_WORD_HIGH = 2'h1;
  localparam logic [1:0] REG_PULL_RANGE = 2'h2;

  // Field layout of the device registers.
  localparam int WORD_WIDTH = 26;
  localparam int HIGH_WIDTH = 10;
  localparam int ENABLE_BIT = 10;
  localparam int RANGE_WIDTH = 4;

  // Values after reset.
  localparam logic [25:0] WORD_RESET = 26'h0000000;
  localparam logic [15:0] WORD_LOW_RESET = 16'h0000;
  localparam logic [3:0] FACTORY_RANGE = 4'h9;
  localparam logic ENABLE_RESET = 1'b0;

  // Positive full half scale; the negative extreme is clamped onto its mirror.
  localparam logic [25:0] WORD_POS_FULL = 26'h1FFFFFF;
  localparam logic [25:0] WORD_NEG_FULL = 26'h2000001;
  localparam logic [25:0] WORD_NEG_EXTREME = 26'h2000000;

  // Pull span per range code in units of 0.01 ppm, narrowest first.
  localparam logic [18:0] SPAN_TABLE [16] = '{
    19'h00271, 19'h003E8, 19'h004E2, 19'h009C4, 19'h01388, 19'h01F40, 19'h02710, 19'h030D4,
    19'h03A98, 19'h04E20, 19'h09C40, 19'h0EA60, 19'h13880, 19'h1D4C0, 19'h27100, 19'h4E200};

  // Frequency step per range code in units of 0.1 ppt.
  localparam logic [9:0] STEP_TABLE [16] = '{
    10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032,
    10'h032, 10'h032, 10'h064, 10'h08C, 10'h0D2, 10'h140, 10'h1D6, 10'h3AC};

  // Host side clock and least spacing of frequency updates.
  localparam int CLK_HZ = 50000000;
  localparam int UPDATE_RATE_HZ = 38000;
  localparam int GAP_CYCLES = (CLK_HZ + UPDATE_RATE_HZ - 1) / UPDATE_RATE_HZ;
  localparam int GAP_WIDTH = 11;

  // Host register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] HOST_FREQ = 8'h00;
  localparam logic [7:0] HOST_RANGE = 8'h04;
  localparam logic [7:0] HOST_READ = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0C;
  localparam int HOST_KEEP_ON_BIT = 26;

  // Host sequencer states.
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } dfp_state_type;

endpackage

// >>> verilog/dfp_link_if.sv
// Link between the host controller and the frequency pull device.
`timescale 1ns/1ns
`default_nettype none
interface dfp_link_if;
  logic link_clk;
  logic req_tgl;
  logic wr;
  logic [1:0] addr;
  logic [15:0] wdata;
  logic ack_tgl;
  logic [15:0] rdata;

  modport device (
    input link_clk,
    input req_tgl,
    input wr,
    input addr,
    input wdata,
    output ack_tgl,
    output rdata
  );

  modport host (
    output req_tgl,
    output wr,
    output addr,
    output wdata,
    input ack_tgl,
    input rdata
  );
endinterface
`default_nettype wire

// >>> verilog/dfp_device.sv
// Register bank of the digitally pulled oscillator, clocked by the link clock.
`timescale 1ns/1ns
`default_nettype none
module dfp_device (
  dfp_link_if.device LINK,
  input wire logic RST_N_I,
  input wire logic OE_PIN_MODE_I,
  input wire logic OE_PIN_I,
  output logic [25:0] FREQ_WORD_O,
  output logic [3:0] PULL_RANGE_O,
  output logic [18:0] PULL_SPAN_O,
  output logic [9:0] STEP_O,
  output logic OUT_EN_O,
  output logic UPDATE_O
);

  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic mode_s1_reg;
  logic mode_s2_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic req_event;
  logic load_reg;
  logic [15:0] low_word_reg;
  logic [25:0] word_reg;
  logic [25:0] word_next;
  logic enable_reg;
  logic [3:0] range_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic ack_reg;
  logic update_reg;
  logic [25:0] clamp_next;
  logic [25:0] freq_reg;

  // The request toggle comes from the host's domain, so it passes two flops before the edge test.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= LINK.req_tgl;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  // The enable mode pin is asynchronous to the link clock and passes two flops.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
    end else begin
      mode_s1_reg <= OE_PIN_MODE_I;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // The enable pin level is asynchronous as well and passes two flops.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= OE_PIN_I;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // A change of the synchronised toggle is one request; address and data are held by the host until acked.
  assign req_event = req_s2_reg ^ req_s3_reg;

  // Lower half waits in a holding register and never touches the frequency on its own.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      low_word_reg <= dfp_pkg::WORD_LOW_RESET;
    end else if (req_event && LINK.wr && LINK.addr == dfp_pkg::REG_WORD_LOW) begin
      low_word_reg <= LINK.wdata;
    end
  end

  // Both halves are joined into one signed word as the upper half is written.
  always_comb begin
    word_next = {LINK.wdata[dfp_pkg::HIGH_WIDTH-1:0], low_word_reg};
  end

  // The active word starts at zero, which is the nominal frequency.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      word_reg <= dfp_pkg::WORD_RESET;
    end else if (req_event && LINK.wr && LINK.addr == dfp_pkg::REG_ENABLE_WORD_HIGH) begin
      word_reg <= word_next;
    end
  end

  // Marks the edge at which an upper-half write loads the active word.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= req_event && LINK.wr && LINK.addr == dfp_pkg::REG_ENABLE_WORD_HIGH;
    end
  end

  // One-cycle pulse, delayed so it stands in the same cycle as the new word on the frequency output.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      update_reg <= 1'b0;
    end else begin
      update_reg <= load_reg;
    end
  end

  // The software enable is written only when the pin does not own the output enable.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      enable_reg <= dfp_pkg::ENABLE_RESET;
    end else if (req_event && LINK.wr && LINK.addr == dfp_pkg::REG_ENABLE_WORD_HIGH && !mode_s2_reg) begin
      enable_reg <= LINK.wdata[dfp_pkg::ENABLE_BIT];
    end
  end

  // Range select starts at the factory value and changes only by a link write.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      range_reg <= dfp_pkg::FACTORY_RANGE;
    end else if (req_event && LINK.wr && LINK.addr == dfp_pkg::REG_PULL_RANGE) begin
      range_reg <= LINK.wdata[dfp_pkg::RANGE_WIDTH-1:0];
    end
  end

  // Read data; unused bits and the spare index read as zero.
  always_comb begin
    rdata_next = 16'h0000;
    if (LINK.addr == dfp_pkg::REG_WORD_LOW) begin
      rdata_next = low_word_reg;
    end else if (LINK.addr == dfp_pkg::REG_ENABLE_WORD_HIGH) begin
      rdata_next = {5'h00, enable_reg, word_reg[dfp_pkg::WORD_WIDTH-1:16]};
    end else if (LINK.addr == dfp_pkg::REG_PULL_RANGE) begin
      rdata_next = {12'h000, range_reg};
    end
  end

  // Read data is loaded at the same edge as the acknowledge, so it is settled before the host sees it.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_reg <= 16'h0000;
    end else if (req_event && !LINK.wr) begin
      rdata_reg <= rdata_next;
    end
  end

  // Every request is answered by flipping the acknowledge toggle once.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_reg <= 1'b0;
    end else if (req_event) begin
      ack_reg <= ~ack_reg;
    end
  end

  // The negative extreme lies one step past the full range, so it is pulled back onto the limit.
  always_comb begin
    clamp_next = word_reg;
    if (word_reg == dfp_pkg::WORD_NEG_EXTREME) begin
      clamp_next = dfp_pkg::WORD_NEG_FULL;
    end
  end

  // Registered word handed to the fractional divider.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      freq_reg <= dfp_pkg::WORD_RESET;
    end else begin
      freq_reg <= clamp_next;
    end
  end

  // Output enable follows the pin under pin control and the software bit otherwise.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_EN_O <= 1'b0;
    end else begin
      OUT_EN_O <= mode_s2_reg ? pin_s2_reg : enable_reg;
    end
  end

  // Span and step lookups; codes ascend from narrowest to widest.
  always_ff @(posedge LINK.link_clk or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PULL_SPAN_O <= dfp_pkg::SPAN_TABLE[dfp_pkg::FACTORY_RANGE];
      STEP_O <= dfp_pkg::STEP_TABLE[dfp_pkg::FACTORY_RANGE];
    end else begin
      PULL_SPAN_O <= dfp_pkg::SPAN_TABLE[range_reg];
      STEP_O <= dfp_pkg::STEP_TABLE[range_reg];
    end
  end

  assign FREQ_WORD_O = freq_reg;
  assign PULL_RANGE_O = range_reg;
  assign UPDATE_O = update_reg;
  assign LINK.ack_tgl = ack_reg;
  assign LINK.rdata = rdata_reg;

endmodule
`default_nettype wire

// >>> verilog/dfp_host.sv
// Host controller: AHB-Lite registers in, paced register writes and reads out over the link.
`timescale 1ns/1ns
`default_nettype none
module dfp_host (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  dfp_link_if.host LINK
);

  dfp_pkg::dfp_state_type state_reg;
  logic bus_wr_reg;
  logic [7:0] bus_addr_reg;
  logic addr_ok;
  logic [26:0] freq_reg;
  logic [3:0] range_reg;
  logic [1:0] read_addr_reg;
  logic pend_low_reg;
  logic pend_high_reg;
  logic pend_range_reg;
  logic pend_read_reg;
  logic [10:0] gap_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_seen_reg;
  logic req_reg;
  logic wr_reg;
  logic [1:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic launch_low;
  logic launch_high;
  logic launch_range;
  logic launch_read;
  logic busy;

  // Address phase is taken when selected, NONSEQ or SEQ, and the bus is ready; the slave never stalls.
  assign addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign busy = pend_low_reg || pend_high_reg || pend_range_reg || pend_read_reg || state_reg == dfp_pkg::ST_WAIT;

  // Write address phase remembered for the data phase.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
    end else begin
      bus_wr_reg <= addr_ok && HWRITE_I;
      bus_addr_reg <= HADDR_I[7:0];
    end
  end

  // Read data is registered in the address phase so it stands through the data phase.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (addr_ok && !HWRITE_I) begin
      if (HADDR_I[7:0] == dfp_pkg::HOST_FREQ) begin
        HRDATA_O <= {5'h00, freq_reg};
      end else if (HADDR_I[7:0] == dfp_pkg::HOST_RANGE) begin
        HRDATA_O <= {28'h0000000, range_reg};
      end else if (HADDR_I[7:0] == dfp_pkg::HOST_STATUS) begin
        HRDATA_O <= {rdata_reg, 14'h0000, gap_reg != 11'h000, busy};
      end else begin
        HRDATA_O <= 32'h00000000;
      end
    end
  end

  // Launch choice: lower half first, upper half only after it and once the update gap has run out.
  assign launch_low = state_reg == dfp_pkg::ST_IDLE && pend_low_reg;
  assign launch_high = state_reg == dfp_pkg::ST_IDLE && !pend_low_reg && pend_high_reg
                       && gap_reg == 11'h000;
  assign launch_range = state_reg == dfp_pkg::ST_IDLE && !pend_low_reg && !launch_high && pend_range_reg;
  assign launch_read = state_reg == dfp_pkg::ST_IDLE && !pend_low_reg && !launch_high && !pend_range_reg
                       && pend_read_reg;

  // Staged values; a new bus write wins over the launch that clears the same pending flag.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      freq_reg <= 27'h0000000;
      range_reg <= dfp_pkg::FACTORY_RANGE;
      read_addr_reg <= 2'h0;
      pend_low_reg <= 1'b0;
      pend_high_reg <= 1'b0;
      pend_range_reg <= 1'b0;
      pend_read_reg <= 1'b0;
    end else begin
      if (launch_low) pend_low_reg <= 1'b0;
      if (launch_high) pend_high_reg <= 1'b0;
      if (launch_range) pend_range_reg <= 1'b0;
      if (launch_read) pend_read_reg <= 1'b0;
      if (bus_wr_reg && bus_addr_reg == dfp_pkg::HOST_FREQ) begin
        freq_reg <= HWDATA_I[26:0];
        pend_low_reg <= 1'b1;
        pend_high_reg <= 1'b1;
      end else if (bus_wr_reg && bus_addr_reg == dfp_pkg::HOST_RANGE) begin
        range_reg <= HWDATA_I[3:0];
        pend_range_reg <= 1'b1;
      end else if (bus_wr_reg && bus_addr_reg == dfp_pkg::HOST_READ) begin
        read_addr_reg <= HWDATA_I[1:0];
        pend_read_reg <= 1'b1;
      end
    end
  end

  // Gap counter restarts at every upper-half launch and holds the next one back until it reaches zero.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gap_reg <= 11'h000;
    end else if (launch_high) begin
      gap_reg <= 11'(dfp_pkg::GAP_CYCLES - 1);
    end else if (gap_reg != 11'h000) begin
      gap_reg <= gap_reg - 11'h001;
    end
  end

  // Acknowledge toggle from the link domain passes two flops; the third copy marks what was seen.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= LINK.ack_tgl;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // One link transfer at a time; fields stay put until the acknowledge comes back.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= dfp_pkg::ST_IDLE;
      req_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 2'h0;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      case (state_reg)
        dfp_pkg::ST_IDLE: begin
          if (launch_low || launch_high || launch_range || launch_read) begin
            state_reg <= dfp_pkg::ST_WAIT;
            req_reg <= ~req_reg;
            wr_reg <= !launch_read;
          end
          if (launch_low) begin
            addr_reg <= dfp_pkg::REG_WORD_LOW;
            wdata_reg <= freq_reg[15:0];
          end else if (launch_high) begin
            addr_reg <= dfp_pkg::REG_ENABLE_WORD_HIGH;
            wdata_reg <= {5'h00, freq_reg[dfp_pkg::HOST_KEEP_ON_BIT], freq_reg[25:16]};
          end else if (launch_range) begin
            addr_reg <= dfp_pkg::REG_PULL_RANGE;
            wdata_reg <= {12'h000, range_reg};
          end else if (launch_read) begin
            addr_reg <= read_addr_reg;
            wdata_reg <= 16'h0000;
          end
        end
        default: begin
          if (ack_s2_reg != ack_seen_reg) begin
            ack_seen_reg <= ack_s2_reg;
            state_reg <= dfp_pkg::ST_IDLE;
            if (!wr_reg) begin
              rdata_reg <= LINK.rdata;
            end
          end
        end
      endcase
    end
  end

  assign LINK.req_tgl = req_reg;
  assign LINK.wr = wr_reg;
  assign LINK.addr = addr_reg;
  assign LINK.wdata = wdata_reg;

endmodule
`default_nettype wire

// >>> verilog/dfp_device_fix.sv
// Spare source file; it holds no logic.

// >>> tb/dfp_link_properties.sv
// Protocol checker for the register link between host controller and device.
`timescale 1ns/1ns
`default_nettype none
module dfp_link_properties (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic link_clk,
  input wire logic req_tgl,
  input wire logic wr,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack_tgl,
  input wire logic [15:0] rdata
);
  logic req_prev_reg;
  logic low_reg;
  logic [11:0] gap_reg;
  logic launch;
  logic high_go;
  logic low_go;
  assign launch = req_tgl != req_prev_reg;
  assign high_go = launch && wr && addr == dfp_pkg::REG_ENABLE_WORD_HIGH;
  assign low_go = launch && wr && addr == dfp_pkg::REG_WORD_LOW;

  // Previous request level, so a launch is seen in the cycle the toggle lands.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      req_prev_reg <= 1'b0;
    end else begin
      req_prev_reg <= req_tgl;
    end
  end

  // Spacing counter saturates, so the first upper write after reset is never flagged.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gap_reg <= 12'hFFF;
      low_reg <= 1'b0;
    end else begin
      gap_reg <= high_go ? 12'h000 : (gap_reg == 12'hFFF ? gap_reg : gap_reg + 12'h001);
      low_reg <= low_go ? 1'b1 : (high_go ? 1'b0 : low_reg);
    end
  end

  sequence s_launch;
    launch;
  endsequence
  sequence s_answered;
    ##[1:20] ack_tgl == req_tgl;
  endsequence

  chk_ack_bounded: assert property (@(posedge CLK_I) disable iff (!RST_N_I) s_launch |-> s_answered)
    else $error("link request not answered in time");
  chk_one_pending: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_launch |-> $past(req_tgl) == $past(ack_tgl))
    else $error("second link request while one was open");
  chk_fields_stable: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (req_tgl != ack_tgl && !launch) |-> $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("link request fields moved while open");
  chk_no_addr3: assert property (@(posedge CLK_I) disable iff (!RST_N_I) s_launch |-> addr != 2'h3)
    else $error("link request to unused register index");
  chk_low_first: assert property (@(posedge CLK_I) disable iff (!RST_N_I) high_go |-> low_reg)
    else $error("upper half sent without a fresh lower half");
  chk_high_gap: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    high_go |-> gap_reg >= 12'(dfp_pkg::GAP_CYCLES - 1))
    else $error("frequency updates closer than the least spacing");
  chk_ack_single: assert property (@(posedge link_clk) disable iff (!RST_N_I)
    $changed(ack_tgl) |-> $past(req_tgl) != $past(ack_tgl))
    else $error("acknowledge without an open request");
  chk_rdata_hold: assert property (@(posedge link_clk) disable iff (!RST_N_I)
    $changed(rdata) |-> $changed(ack_tgl) && !wr)
    else $error("read data moved outside a read answer");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench: host and device joined over the link, driven over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pin_mode = 1'b0;
  logic pin_lvl = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [25:0] freq_word;
  logic [3:0] pull_range;
  logic [18:0] pull_span;
  logic [9:0] step;
  logic out_en;
  logic update;
  logic [25:0] freq_prev = 26'h0;
  int err_total = 0;
  int tests_run = 0;
  int upd_cnt = 0;
  // Half spans in 0.01 ppm and steps in 0.1 ppt, narrowest code first.
  int span_exp [16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12500, 15000, 20000, 40000, 60000,
    80000, 120000, 160000, 320000};
  int step_exp [16] = '{50, 50, 50, 50, 50, 50, 50, 50, 50, 50, 100, 140, 210, 320, 470, 940};

  dfp_link_if lnk ();
  assign lnk.link_clk = link_clk;
  always #10 clk = ~clk;
  // Offset start keeps the 12 ns link clock out of step with the bus clock.
  initial #3 forever #6 link_clk = ~link_clk;

  dfp_host dfp_host_i (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
    .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .LINK(lnk));
  dfp_device dfp_device_i (.LINK(lnk), .RST_N_I(rst_n), .OE_PIN_MODE_I(pin_mode), .OE_PIN_I(pin_lvl),
    .FREQ_WORD_O(freq_word), .PULL_RANGE_O(pull_range), .PULL_SPAN_O(pull_span), .STEP_O(step),
    .OUT_EN_O(out_en), .UPDATE_O(update));
  dfp_link_properties dfp_link_properties_i (.CLK_I(clk), .RST_N_I(rst_n), .link_clk(lnk.link_clk),
    .req_tgl(lnk.req_tgl), .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .ack_tgl(lnk.ack_tgl),
    .rdata(lnk.rdata));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single transfer; the wait loops keep the bus rules even though this slave never stalls.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wait_idle();
    logic [31:0] q;
    q = 32'h1;
    for (int n = 0; n < 3000 && q[0] !== 1'b0; n++) ahb(1'b0, dfp_pkg::HOST_STATUS, 32'h0, q);
    check("busy", q[0], 32'h0);
  endtask

  task automatic dev_read(input logic [1:0] idx, input logic [15:0] exp);
    logic [31:0] q;
    ahb(1'b1, dfp_pkg::HOST_READ, {30'h0, idx}, q);
    wait_idle();
    ahb(1'b0, dfp_pkg::HOST_STATUS, 32'h0, q);
    check("device read", q[31:16], exp);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // Any move of the applied word must come with the update strobe.
  always @(posedge link_clk) begin
    if (rst_n === 1'b1 && freq_word !== freq_prev) check("strobe", update, 32'h1);
    if (update === 1'b1) upd_cnt++;
    freq_prev <= freq_word;
  end

  task automatic t_reset_values();
    check("word", freq_word, 32'h0);
    check("range", pull_range, dfp_pkg::FACTORY_RANGE);
    check("span", pull_span, span_exp[dfp_pkg::FACTORY_RANGE]);
    check("enable", out_en, 32'h0);
    $display("test reset values done");
  endtask

  task automatic t_range_codes();
    logic [31:0] q;
    for (int c = 0; c < 16; c++) begin
      ahb(1'b1, dfp_pkg::HOST_RANGE, 32'hABCDFFF0 | c, q);
      wait_idle();
      check("range", pull_range, c);
      check("span", pull_span, span_exp[c]);
      check("step", step, step_exp[c]);
    end
    $display("test range codes done");
  endtask

  task automatic t_freq_words();
    logic [26:0] tab [4] = '{{1'b1, 26'h0E66666}, {1'b0, 26'h3800000}, {1'b1, 26'h2000000}, {1'b0, 26'h1FFFFFF}};
    logic [31:0] q;
    logic [25:0] e;
    int base;
    for (int i = 0; i < 4; i++) begin
      base = upd_cnt;
      e = tab[i][25:0] == 26'h2000000 ? 26'h2000001 : tab[i][25:0];
      ahb(1'b1, dfp_pkg::HOST_FREQ, {5'h0, tab[i]}, q);
      wait_idle();
      check("word", freq_word, e);
      check("enable", out_en, tab[i][26]);
      check("strobes", upd_cnt - base, 32'h1);
    end
    dev_read(2'h0, 16'hFFFF);
    dev_read(2'h1, 16'h01FF);
    dev_read(2'h2, 16'h000F);
    ahb(1'b1, dfp_pkg::HOST_STATUS, 32'hFFFFFFFF, q);
    ahb(1'b0, 8'h10, 32'h0, q);
    check("unmapped", q, 32'h0);
    ahb(1'b0, dfp_pkg::HOST_STATUS, 32'h0, q);
    check("status", q[31:16], 32'h000F);
    $display("test frequency words done");
  endtask

  // Pin control must win; the software bit written meanwhile stays unchanged.
  task automatic t_oe_pin();
    logic [31:0] q;
    pin_mode <= 1'b1;
    repeat (6) @(posedge clk);
    ahb(1'b1, dfp_pkg::HOST_FREQ, {5'h0, 1'b1, 26'h0000123}, q);
    wait_idle();
    check("word", freq_word, 32'h123);
    check("enable", out_en, 32'h0);
    pin_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    check("enable", out_en, 32'h1);
    pin_mode <= 1'b0;
    pin_lvl <= 1'b0;
    repeat (6) @(posedge clk);
    check("enable", out_en, 32'h0);
    $display("test enable pin done");
  endtask

  task automatic conclude();
    $display("tests run %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    conclude();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_range_codes();
    t_freq_words();
    t_oe_pin();
    do_reset();
    t_reset_values();
    conclude();
  end
endmodule
`default_nettype wire
